// File: rtl/brg_pkg.sv
// constants, register map and decode helpers for the baud rate generator
package brg_pkg;
	localparam int ADDR_W = 3;
	localparam int DATA_W = 8;
	localparam int DIV_W  = 16;
	localparam int PRE_W  = 6;
	localparam int POS_W  = 2;

	// clock period of sys_clk
	localparam int CLK_PERIOD_NS = 10;

	// register offsets
	localparam logic [ADDR_W-1:0] OFF_TX_STATUS_CONTROL = 3'h0;
	localparam logic [ADDR_W-1:0] OFF_RX_STATUS_CONTROL = 3'h1;
	localparam logic [ADDR_W-1:0] OFF_BAUD_CONTROL      = 3'h2;
	localparam logic [ADDR_W-1:0] OFF_BAUD_DIVISOR_LOW  = 3'h3;
	localparam logic [ADDR_W-1:0] OFF_BAUD_DIVISOR_HIGH = 3'h4;

	// reset values
	localparam logic [DATA_W-1:0] RST_TX_STATUS_CONTROL = 8'h02;
	localparam logic [DATA_W-1:0] RST_RX_STATUS_CONTROL = 8'h00;
	localparam logic [DATA_W-1:0] RST_BAUD_CONTROL      = 8'h40;
	localparam logic [DATA_W-1:0] RST_BAUD_DIVISOR      = 8'h00;

	// field positions
	localparam int TX_SYNC_BIT = 4;
	localparam int TX_HS_BIT   = 2;
	localparam int TX_TRMT_BIT = 1;
	localparam int RX_SPEN_BIT = 7;
	localparam int BC_IDLE_BIT = 6;
	localparam int BC_WIDE_BIT = 3;

	// writable bits; the others are status or unimplemented
	localparam logic [DATA_W-1:0] WMASK_TX_STATUS_CONTROL = 8'hfd;
	localparam logic [DATA_W-1:0] WMASK_RX_STATUS_CONTROL = 8'hf8;
	localparam logic [DATA_W-1:0] WMASK_BAUD_CONTROL      = 8'h9b;

	// prescale terminal counts: factor minus one
	localparam logic [PRE_W-1:0] PRE_M1_64 = 6'h3f;
	localparam logic [PRE_W-1:0] PRE_M1_16 = 6'h0f;
	localparam logic [PRE_W-1:0] PRE_M1_4  = 6'h03;

	// positions of the three line samples inside one bit
	localparam logic [POS_W-1:0] SMP_POS_FIRST = 2'h0;
	localparam logic [POS_W-1:0] SMP_POS_MID   = 2'h1;
	localparam logic [POS_W-1:0] SMP_POS_LAST  = 2'h2;

	localparam logic [DATA_W-1:0] ZERO_BYTE = 8'h00;
	localparam logic [DIV_W-1:0]  DIV_ZERO  = 16'h0000;
	localparam logic [DIV_W-1:0]  DIV_ONE   = 16'h0001;
	localparam logic [PRE_W-1:0]  PRE_ZERO  = 6'h00;
	localparam logic [PRE_W-1:0]  PRE_ONE   = 6'h01;
	localparam logic [PRE_W-1:0]  PRE_TWO   = 6'h02;

	// division factor minus one for the mode bits
	function automatic logic [PRE_W-1:0] prescale_m1(input logic sync, input logic hs, input logic wide);
		if (sync)
			return PRE_M1_4;
		else if (hs && wide)
			return PRE_M1_4;
		else if (hs || wide)
			return PRE_M1_16;
		else
			return PRE_M1_64;
	endfunction

	// majority of three samples
	function automatic logic maj3(input logic a, input logic b, input logic c);
		return (a & b) | (a & c) | (b & c);
	endfunction
endpackage

// File: rtl/brg_if.sv
// sample strobes from the divider to the receive-line sampler
`timescale 1ns/1ps
interface brg_if;
	logic                      sample_stb;
	logic [brg_pkg::POS_W-1:0] sample_pos;
	logic                      rx_pin;
	logic                      rx_level;

	modport gen (output sample_stb, output sample_pos, output rx_pin, input rx_level);
	modport smp (input sample_stb, input sample_pos, input rx_pin, output rx_level);
endinterface

// File: rtl/rx_majority_sampler.sv
// three-sample majority detector on the receive line
`timescale 1ns/1ps
module rx_majority_sampler (
	input  wire logic sys_clk,
	input  wire logic reset,
	brg_if.smp        bus
);
	import brg_pkg::*;

	logic s0_r;
	logic s1_r;
	logic level_r;

	// samples one and two are held, the third resolves the vote directly
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			s0_r    <= 1'b1;
			s1_r    <= 1'b1;
			level_r <= 1'b1;
		end else if (bus.sample_stb) begin
			if (bus.sample_pos == SMP_POS_FIRST)
				s0_r <= bus.rx_pin;
			if (bus.sample_pos == SMP_POS_MID)
				s1_r <= bus.rx_pin;
			if (bus.sample_pos == SMP_POS_LAST)
				level_r <= maj3(s0_r, s1_r, bus.rx_pin);
		end
	end

	assign bus.rx_level = level_r;

	a_vote_majority: assert property (@(posedge sys_clk) disable iff (reset)
		bus.sample_stb && bus.sample_pos == SMP_POS_LAST
		|=> level_r == maj3($past(s0_r), $past(s1_r), $past(bus.rx_pin)))
		else $error("voted level is not the majority of three samples");

	a_level_holds: assert property (@(posedge sys_clk) disable iff (reset)
		!(bus.sample_stb && bus.sample_pos == SMP_POS_LAST) |=> $stable(level_r))
		else $error("voted level changed without a third sample");

	c_low_vote: cover property (@(posedge sys_clk) disable iff (reset) $fell(level_r));
endmodule // rx_majority_sampler

// File: rtl/serial_baud_rate_generator.sv
// baud rate generator with register port and receive-line sampler
//
// Our own choices: strobed register access and the address map.
`timescale 1ns/1ps

// Notes on behaviour
// - tick timing counts only sys_clk cycles
// - receive level is majority of three samples
// - async, 8-bit, low speed: divide by 64(n+1)
// - async, 16-bit, low speed: divide by 16(n+1)
// - sync ignores high speed: divide by 4(n+1)
// - divisor is high byte above low byte
// - narrow divider ignores high byte by default
// - divisor write clears the free-running timer
module serial_baud_rate_generator (
	input  wire logic                          sys_clk,
	input  wire logic                          reset,
	input  wire logic [brg_pkg::ADDR_W-1:0]    addr,
	input  wire logic [brg_pkg::DATA_W-1:0]    wr_data,
	input  wire logic                          wr_en,
	input  wire logic                          rd_en,
	output logic      [brg_pkg::DATA_W-1:0]    rd_data,
	input  wire logic                          rx_in,
	output logic                               baud_tick,
	output logic                               rx_level
);
	import brg_pkg::*;

	logic [DATA_W-1:0] tx_ctl_r;
	logic [DATA_W-1:0] rx_ctl_r;
	logic [DATA_W-1:0] baud_ctl_r;
	logic [DATA_W-1:0] div_low_r;
	logic [DATA_W-1:0] div_high_r;
	logic [DATA_W-1:0] rd_data_r;
	logic [DATA_W-1:0] rd_data_nxt;
	logic [DIV_W-1:0]  div_cnt_r;
	logic [DIV_W-1:0]  div_cnt_nxt;
	logic [PRE_W-1:0]  pre_cnt_r;
	logic [PRE_W-1:0]  pre_cnt_nxt;
	logic              tick_r;
	logic              tick_nxt;
	logic              stb_r;
	logic              stb_nxt;
	logic [POS_W-1:0]  pos_r;
	logic [POS_W-1:0]  pos_nxt;
	logic              level_r;

	brg_if link ();

	// register decode
	wire wr_tx    = wr_en && addr == OFF_TX_STATUS_CONTROL;
	wire wr_rx    = wr_en && addr == OFF_RX_STATUS_CONTROL;
	wire wr_baud  = wr_en && addr == OFF_BAUD_CONTROL;
	wire wr_low   = wr_en && addr == OFF_BAUD_DIVISOR_LOW;
	wire wr_high  = wr_en && addr == OFF_BAUD_DIVISOR_HIGH;
	wire div_write = wr_low || wr_high;

	// mode bits steering the divider
	// mode changes act at once; only a divisor write or clearing port_enable restarts the timer
	wire sync_mode = tx_ctl_r[TX_SYNC_BIT];
	wire high_speed_select   = tx_ctl_r[TX_HS_BIT];
	wire wide_divider_enable = baud_ctl_r[BC_WIDE_BIT];
	wire port_enable = rx_ctl_r[RX_SPEN_BIT];

	// divisor: high byte only counts in wide mode
	wire [DIV_W-1:0] divisor = wide_divider_enable ? {div_high_r, div_low_r}
		: {ZERO_BYTE, div_low_r};
	wire [PRE_W-1:0] pre_m1 = prescale_m1(sync_mode, high_speed_select, wide_divider_enable);

	// disabled port holds the divider in reset
	wire div_clear = !port_enable || div_write;
	// compare with >= so a shrinking divisor or factor cannot strand the count
	wire div_wrap  = div_cnt_r >= divisor;
	wire pre_last  = pre_cnt_r >= pre_m1;
	wire [PRE_W-1:0] pre_mid  = pre_m1 >> 1;
	wire [PRE_W-1:0] pre_off  = pre_cnt_r - pre_mid;
	wire             in_window = pre_cnt_r >= pre_mid && pre_off <= PRE_TWO;

	// divider next state
	// prescale steps only on a divider wrap, so the factor multiplies (n+1)
	assign div_cnt_nxt = (div_clear || div_wrap) ? DIV_ZERO : div_cnt_r + DIV_ONE;
	assign pre_cnt_nxt = div_clear ? PRE_ZERO
		: div_wrap ? (pre_last ? PRE_ZERO : pre_cnt_r + PRE_ONE) : pre_cnt_r;
	assign tick_nxt    = !div_clear && div_wrap && pre_last;
	assign stb_nxt     = !div_clear && div_wrap && in_window;
	assign pos_nxt     = pre_off[POS_W-1:0];

	// divider and prescale counters
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			div_cnt_r <= DIV_ZERO;
			pre_cnt_r <= PRE_ZERO;
			tick_r    <= 1'b0;
			stb_r     <= 1'b0;
			pos_r     <= SMP_POS_FIRST;
		end else begin
			div_cnt_r <= div_cnt_nxt;
			pre_cnt_r <= pre_cnt_nxt;
			tick_r    <= tick_nxt;
			stb_r     <= stb_nxt;
			pos_r     <= pos_nxt;
		end
	end

	// software registers; status bits are masked from writes
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			tx_ctl_r   <= RST_TX_STATUS_CONTROL;
			rx_ctl_r   <= RST_RX_STATUS_CONTROL;
			baud_ctl_r <= RST_BAUD_CONTROL;
			div_low_r  <= RST_BAUD_DIVISOR;
			div_high_r <= RST_BAUD_DIVISOR;
		end else begin
			if (wr_tx)
				tx_ctl_r <= (wr_data & WMASK_TX_STATUS_CONTROL) | (tx_ctl_r & ~WMASK_TX_STATUS_CONTROL);
			if (wr_rx)
				rx_ctl_r <= (wr_data & WMASK_RX_STATUS_CONTROL) | (rx_ctl_r & ~WMASK_RX_STATUS_CONTROL);
			if (wr_baud)
				baud_ctl_r <= (wr_data & WMASK_BAUD_CONTROL) | (baud_ctl_r & ~WMASK_BAUD_CONTROL);
			if (wr_low)
				div_low_r <= wr_data;
			if (wr_high)
				div_high_r <= wr_data;
		end
	end

	// read mux; no transmitter here, so the shift register always reads empty
	// status bits are rebuilt at read time rather than stored
	// unmapped places read zero so software can probe the map safely
	wire [DATA_W-1:0] tx_view   = tx_ctl_r | (DATA_W'(1'b1) << TX_TRMT_BIT);
	wire [DATA_W-1:0] idle_mask = DATA_W'(1'b1) << BC_IDLE_BIT;
	wire [DATA_W-1:0] baud_view = (baud_ctl_r & ~idle_mask) | (level_r ? idle_mask : ZERO_BYTE);
	always_comb begin
		rd_data_nxt = ZERO_BYTE;
		unique case (addr)
			OFF_TX_STATUS_CONTROL: rd_data_nxt = tx_view;
			OFF_RX_STATUS_CONTROL: rd_data_nxt = rx_ctl_r;
			OFF_BAUD_CONTROL:      rd_data_nxt = baud_view;
			OFF_BAUD_DIVISOR_LOW:  rd_data_nxt = div_low_r;
			OFF_BAUD_DIVISOR_HIGH: rd_data_nxt = div_high_r;
			default:               rd_data_nxt = ZERO_BYTE;
		endcase
	end

	// read data stands only in the cycle after the strobe
	always_ff @(posedge sys_clk) begin
		if (reset)
			rd_data_r <= ZERO_BYTE;
		else
			rd_data_r <= rd_en ? rd_data_nxt : ZERO_BYTE;
	end

	// the line is taken directly, the input is already synchronous
	// no extra synchroniser: it would only shift the sample points by a cycle
	assign link.sample_stb = stb_r;
	assign link.sample_pos = pos_r;
	assign link.rx_pin     = rx_in;
	assign level_r         = link.rx_level;

	rx_majority_sampler u_sampler (
		.sys_clk (sys_clk),
		.reset   (reset),
		.bus     (link.smp)
	);

	assign rd_data   = rd_data_r;
	assign baud_tick = tick_r;
	assign rx_level  = level_r;

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (reset);

	a_write_clears: assert property (div_write |=> div_cnt_r == DIV_ZERO && pre_cnt_r == PRE_ZERO)
		else $error("divisor write did not clear the timer");
	a_narrow_ignores_high: assert property (!wide_divider_enable |-> divisor[DIV_W-1:DATA_W] == ZERO_BYTE)
		else $error("high divisor byte used in narrow mode");
	a_wide_pair: assert property (wide_divider_enable |-> divisor == {div_high_r, div_low_r})
		else $error("wide divisor is not high byte over low byte");
	a_factor_slow: assert property (!sync_mode && !high_speed_select && !wide_divider_enable |-> pre_m1 == PRE_M1_64)
		else $error("async slow narrow mode not divide by 64");
	a_factor_wide: assert property (!sync_mode && !high_speed_select && wide_divider_enable |-> pre_m1 == PRE_M1_16)
		else $error("async slow wide mode not divide by 16");
	a_factor_sync: assert property (sync_mode |-> pre_m1 == PRE_M1_4)
		else $error("sync mode not divide by 4");
	a_factor_fast: assert property (!sync_mode && high_speed_select |-> pre_m1 == (wide_divider_enable ? PRE_M1_4 : PRE_M1_16))
		else $error("async fast mode factor wrong");
	a_tick_cause: assert property (baud_tick |-> $past(div_wrap) && $past(pre_last) && $past(port_enable) && !$past(div_write))
		else $error("tick without divider and prescale terminal count");
	a_fast_period: assert property (baud_tick && sync_mode && divisor == DIV_ZERO && $stable(divisor)
		&& !div_write ##1 (!div_write && $stable(tx_ctl_r) && $stable(divisor) && port_enable)[*3] |=> baud_tick)
		else $error("sync tick period with divisor zero is not four cycles");
	a_strobe_before_tick: assert property (baud_tick |-> !stb_r || pos_r == SMP_POS_LAST)
		else $error("tick landed before the sample window closed");

	// divider counts plain clock cycles and nothing else
	a_count_steps: assert property (!div_wrap && !div_clear |=> div_cnt_r == $past(div_cnt_r) + DIV_ONE)
		else $error("divider did not count one per clock");
	a_count_wraps: assert property (div_wrap && !div_clear |=> div_cnt_r == DIV_ZERO)
		else $error("divider did not restart after its terminal count");
	a_prescale_hold: assert property (!div_wrap && !div_clear |=> pre_cnt_r == $past(pre_cnt_r))
		else $error("prescale moved without a divider wrap");
	a_prescale_clear: assert property (div_clear |=> pre_cnt_r == PRE_ZERO)
		else $error("prescale not cleared by write or disable");
	a_disabled_quiet: assert property (!port_enable |=> !baud_tick && !stb_r)
		else $error("tick or strobe while the port is disabled");
	a_tick_single: assert property (baud_tick |=> !baud_tick)
		else $error("baud tick stood for more than one cycle");
	a_narrow_low_only: assert property (!wide_divider_enable |-> divisor[DATA_W-1:0] == div_low_r)
		else $error("narrow divisor is not the low byte");

	// sample strobes come from divider wraps inside the window only
	a_strobe_cause: assert property (stb_r |-> $past(div_wrap) && $past(port_enable) && !$past(div_write))
		else $error("sample strobe without a divider wrap");
	a_strobe_position: assert property (stb_r |-> pos_r <= SMP_POS_LAST)
		else $error("sample strobe outside the three positions");

	// divisor registers read back as written, and only for one cycle
	a_read_div_high: assert property (rd_en && addr == OFF_BAUD_DIVISOR_HIGH |=> rd_data == $past(div_high_r))
		else $error("high divisor byte read back wrong");
	a_read_div_low: assert property (rd_en && addr == OFF_BAUD_DIVISOR_LOW |=> rd_data == $past(div_low_r))
		else $error("low divisor byte read back wrong");
	a_read_idle: assert property (!rd_en |=> rd_data == ZERO_BYTE)
		else $error("read data stood without a read strobe");

	c_tick_slow: cover property (baud_tick && pre_m1 == PRE_M1_64);
	c_tick_fast: cover property (baud_tick && pre_m1 == PRE_M1_4 && wide_divider_enable);
	c_third_sample: cover property (stb_r && pos_r == SMP_POS_LAST);
	c_rewrite: cover property (div_write ##[1:20] baud_tick);
endmodule // serial_baud_rate_generator

// File: tb/serial_line_model.sv
// remote transmitter model driving the receive line
`timescale 1ns/1ps
module serial_line_model (
	input  wire logic sys_clk,
	input  wire logic reset,
	input  wire logic level,
	input  wire logic glitch_en,
	output logic      line_r
);
	logic [1:0] ph_r;

	// one inverted cycle in four: with samples three cycles apart, as the bench sets, it never hits two samples of one bit
	always_ff @(posedge sys_clk) begin
		ph_r   <= reset ? 2'h0 : ph_r + 2'h1;
		line_r <= reset ? 1'b1 : (glitch_en && ph_r == 2'h0) ? ~level : level;
	end
endmodule // serial_line_model

// File: tb/serial_baud_rate_generator_tb.sv
// self-checking bench for the baud rate generator
`timescale 1ns/1ps
module serial_baud_rate_generator_tb;
	import brg_pkg::*;
	logic              sys_clk   = 1'b0;
	logic              reset     = 1'b1;
	logic              wr_en     = 1'b0;
	logic              rd_en     = 1'b0;
	logic              level     = 1'b1;
	logic              glitch_en = 1'b0;
	logic [ADDR_W-1:0] addr      = 3'h0;
	logic [DATA_W-1:0] wr_data   = 8'h00;
	logic [DATA_W-1:0] rd_data;
	logic [DATA_W-1:0] got;
	logic              rx_in;
	logic              baud_tick;
	logic              rx_level;
	int                failures  = 0;
	int                checked   = 0;
	int                cyc       = 0;

	serial_baud_rate_generator u_dut (.sys_clk(sys_clk), .reset(reset), .addr(addr), .wr_data(wr_data),
		.wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .rx_in(rx_in), .baud_tick(baud_tick),
		.rx_level(rx_level));
	serial_line_model u_line (.sys_clk(sys_clk), .reset(reset), .level(level), .glitch_en(glitch_en),
		.line_r(rx_in));

	always #5 sys_clk = ~sys_clk;

	task automatic summarize();
		if (failures == 0 && checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// watchdog: the whole sequence needs well under this many cycles
	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		if (cyc == 60000) begin
			failures++;
			summarize();
		end
	end

	task automatic cmp(input string what, input logic [15:0] exp, input logic [15:0] seen);
		checked++;
		if (seen !== exp) begin
			failures++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// one idle cycle after each strobe keeps every signal to one assignment per step
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		addr <= a;
		wr_data <= d;
		wr_en <= 1'b1;
		@(posedge sys_clk);
		wr_en <= 1'b0;
		@(posedge sys_clk);
	endtask

	task automatic rd(input logic [ADDR_W-1:0] a);
		addr <= a;
		rd_en <= 1'b1;
		@(posedge sys_clk);
		rd_en <= 1'b0;
		@(negedge sys_clk);
		got = rd_data;
		@(posedge sys_clk);
	endtask

	// cycles until the next tick, bounded
	task automatic gap(input string what, input int exp);
		int cnt;
		cnt = 0;
		do begin
			@(negedge sys_clk);
			cnt++;
		end while (baud_tick !== 1'b1 && cnt < 9000);
		cmp(what, exp[15:0], cnt[15:0]);
		@(posedge sys_clk);
	endtask

	// program mode and divisor, low byte last so its write restarts the timer
	task automatic rate(input logic s, input logic h, input logic w, input logic [7:0] hi, input logic [7:0] lo);
		int p;
		p = (s || (h && w)) ? 4 : (h || w) ? 16 : 64;
		p = p * (int'(w ? {hi, lo} : {8'h00, lo}) + 1);
		wr(OFF_TX_STATUS_CONTROL, {3'h0, s, 1'b0, h, 2'h0});
		wr(OFF_BAUD_CONTROL, {4'h0, w, 3'h0});
		wr(OFF_BAUD_DIVISOR_HIGH, hi);
		wr(OFF_BAUD_DIVISOR_LOW, lo);
		gap("first tick", p);
		gap("tick period", p);
	endtask

	// line held at lv with glitches; voted level must never follow a lone glitch
	task automatic vote(input logic lv);
		int bad;
		level <= lv;
		glitch_en <= 1'b1;
		repeat (100) @(posedge sys_clk);
		bad = 0;
		repeat (200) begin
			@(negedge sys_clk);
			bad += (rx_level !== lv);
		end
		@(posedge sys_clk);
		cmp("voted level", 16'h0000, bad[15:0]);
		rd(OFF_BAUD_CONTROL);
		cmp("idle bit", {15'h0000, lv}, {15'h0000, got[BC_IDLE_BIT]});
	endtask

	// reset values, writes and read-backs for places 0..5; place 5 is unmapped
	logic [DATA_W-1:0] rst_v [6] = '{RST_TX_STATUS_CONTROL, RST_RX_STATUS_CONTROL, RST_BAUD_CONTROL,
		RST_BAUD_DIVISOR, RST_BAUD_DIVISOR, ZERO_BYTE};
	logic [DATA_W-1:0] wv    [6] = '{8'hff, 8'h0f, 8'hff, 8'ha5, 8'h3c, 8'hff};
	logic [DATA_W-1:0] rv    [6] = '{8'hff, 8'h08, 8'hdb, 8'ha5, 8'h3c, 8'h00};

	initial begin
		repeat (16) @(posedge sys_clk);
		reset <= 1'b0;
		@(posedge sys_clk);
		// reset values, then write masks, read-only bits and an unmapped place
		for (int i = 0; i < 6; i++) begin
			rd(i[2:0]);
			cmp("reset value", {8'h00, rst_v[i]}, {8'h00, got});
		end
		for (int i = 0; i < 6; i++) begin
			wr(i[2:0], wv[i]);
			rd(i[2:0]);
			cmp("read back", {8'h00, rv[i]}, {8'h00, got});
		end
		wr(OFF_RX_STATUS_CONTROL, 8'h80);
		rate(1'b0, 1'b0, 1'b0, 8'h01, 8'h02);
		rate(1'b0, 1'b0, 1'b0, 8'h00, 8'h00);
		rate(1'b0, 1'b0, 1'b1, 8'h01, 8'h01);
		rate(1'b1, 1'b1, 1'b0, 8'h00, 8'h00);
		rate(1'b1, 1'b0, 1'b1, 8'h01, 8'h00);
		rate(1'b0, 1'b1, 1'b1, 8'h00, 8'h02);
		rate(1'b0, 1'b1, 1'b0, 8'h00, 8'h02);
		vote(1'b0);
		vote(1'b1);
		summarize();
	end
endmodule // serial_baud_rate_generator_tb
